/* File: rtl/dbio_io_ports.v */
// Dual bidirectional I/O ports with an Avalon-MM register slave
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`include "dbio_consts.vh"
module dbio_io_ports (
    // Clock and reset
    input  wire                       clock,
    input  wire                       resetn,
    input  wire                       power_on_reset,
    input  wire                       small_package,
    // Avalon-MM slave
    input  wire [`DBIO_ADDR_W-1:0]    address,
    input  wire                       read,
    input  wire                       write,
    input  wire [31:0]                writedata,
    input  wire [3:0]                 byteenable,
    output reg  [31:0]                readdata,
    output reg                        waitrequest,
    // First port pins
    input  wire [`DBIO_FIRST_W-1:0]   first_port_in,
    output reg  [`DBIO_FIRST_W-1:0]   first_port_out,
    output reg  [`DBIO_FIRST_W-1:0]   first_port_oe,
    // Second port pins
    input  wire [`DBIO_SECOND_W-1:0]  second_port_in,
    output reg  [`DBIO_SECOND_W-1:0]  second_port_out,
    output reg  [`DBIO_SECOND_W-1:0]  second_port_oe,
    output reg  [`DBIO_SECOND_W-1:0]  second_port_pullup,
    // Peripheral side
    output reg                        external_timer_clock,
    output reg                        external_interrupt,
    output reg                        slave_select_n,
    output reg                        lowvolt_detect_in,
    output reg  [`DBIO_FIRST_W-1:0]   first_port_analog,
    output reg  [1:0]                 second_port_analog,
    output reg  [2:0]                 reference_config
);

    // Registers
    reg  [`DBIO_FIRST_W-1:0]   first_port_latch;
    reg  [`DBIO_FIRST_W-1:0]   first_port_direction;
    reg  [`DBIO_SECOND_W-1:0]  second_port_latch;
    reg  [`DBIO_SECOND_W-1:0]  second_port_direction;
    reg  [7:0]                 option_reg;
    reg  [7:0]                 analog_pin_config;
    reg  [5:0]                 periph_enable;

    wire [13:0]                pins_sampled;
    wire [`DBIO_FIRST_W-1:0]   first_pins;
    wire [`DBIO_SECOND_W-1:0]  second_pins;

    // Pins registered every edge; a read returns the levels sampled one edge before its request edge
    dbio_pin_sample #(
        .WIDTH (14)
    ) u_sample (
        .clock   (clock),
        .resetn  (resetn),
        .pins    ({second_port_in, first_port_in}),
        .sampled (pins_sampled)
    );

    assign first_pins  = pins_sampled[5:0];
    assign second_pins = pins_sampled[13:6];

    // Analog pin mask from the config code; codes 6 and up are all digital
    function [5:0] analog_mask;
        input [3:0] pcfg;
        begin
            case (pcfg)
                4'h0:    analog_mask = `DBIO_ANALOG_CAPABLE;
                4'h1:    analog_mask = 6'h0f;
                4'h2:    analog_mask = 6'h07;
                4'h3:    analog_mask = 6'h03;
                4'h4:    analog_mask = 6'h01;
                4'h5:    analog_mask = 6'h2c;
                default: analog_mask = 6'h00;
            endcase
        end
    endfunction

    function idx_hit;
        input [`DBIO_ADDR_W-1:0] addr;
        input [7:0]              idx;
        begin
            idx_hit = (addr == {idx, 2'b00});
        end
    endfunction

    // Derived pin state
    wire [5:0] first_analog = analog_mask(analog_pin_config[`DBIO_PCFG_HI:`DBIO_PCFG_LO]);
    wire [5:0] first_present = small_package ? 6'h1f : 6'h3f;
    wire [7:0] second_periph = {4'h0, periph_enable[`DBIO_PER_ANALOG9]
                                      | periph_enable[`DBIO_PER_LOWVOLT],
                                      periph_enable[`DBIO_PER_ANALOG8],
                                      periph_enable[`DBIO_PER_SLAVE_SEL],
                                      periph_enable[`DBIO_PER_EXT_INT]};
    wire [7:0] second_analog = {4'h0, periph_enable[`DBIO_PER_ANALOG9],
                                      periph_enable[`DBIO_PER_ANALOG8], 2'b00};

    // Digital read values; analog pins read zero
    wire [5:0] first_read  = first_pins & ~first_analog & first_present;
    wire [7:0] second_read = second_pins & ~second_analog;

    // Bus handshake: one wait cycle, then the access completes
    wire       req     = read | write;
    wire       done    = req & ~waitrequest;
    wire       wr_done = write & done & byteenable[0];

    // Latch write data: wr_done drops a write without byte lane 0, so the latch then keeps its own value
    wire [5:0] first_wr  = byteenable[0] ? writedata[5:0] : first_read;
    wire [7:0] second_wr = byteenable[0] ? writedata[7:0] : second_read;

    reg  [31:0] next_readdata;
    reg  [5:0]  next_first_oe;
    reg  [5:0]  next_first_out;
    reg  [7:0]  next_second_oe;
    reg  [7:0]  next_second_pullup;

    always @(posedge clock) begin
        if (!resetn) begin
            waitrequest <= 1'b1;
        end else if (req && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    always @* begin
        next_readdata = 32'h0000_0000;
        if (idx_hit(address, `DBIO_IDX_FIRST_DATA)) begin
            next_readdata[5:0] = first_read;
        end else if (idx_hit(address, `DBIO_IDX_FIRST_DIR)) begin
            next_readdata[5:0] = first_port_direction;
        end else if (idx_hit(address, `DBIO_IDX_SECOND_DATA)) begin
            next_readdata[7:0] = second_read;
        end else if (idx_hit(address, `DBIO_IDX_SECOND_DIR)) begin
            next_readdata[7:0] = second_port_direction;
        end else if (idx_hit(address, `DBIO_IDX_OPTION)) begin
            next_readdata[7:0] = option_reg;
        end else if (idx_hit(address, `DBIO_IDX_ANALOG_CFG)) begin
            next_readdata[7:0] = analog_pin_config;
        end else if (idx_hit(address, `DBIO_IDX_PERIPH_EN)) begin
            next_readdata[5:0] = periph_enable;
        end else if (idx_hit(address, `DBIO_IDX_PIN_MODE)) begin
            next_readdata[5:0] = first_analog;
        end
    end

    // Read data latched on the first request edge, valid at completion
    always @(posedge clock) begin
        if (!resetn) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= next_readdata;
        end
    end

    // Register writes
    always @(posedge clock) begin
        if (!resetn) begin
            // Only power-on clears bit 4; other resets keep it
            if (power_on_reset) begin
                first_port_latch <= `DBIO_RST_FIRST_LATCH;
            end else begin
                first_port_latch <= first_port_latch & 6'h10;
            end
            first_port_direction  <= `DBIO_RST_FIRST_DIR;
            second_port_latch     <= `DBIO_RST_SECOND_LATCH;
            second_port_direction <= `DBIO_RST_SECOND_DIR;
            option_reg            <= `DBIO_RST_OPTION;
            analog_pin_config     <= `DBIO_RST_ANALOG_CFG;
            periph_enable         <= `DBIO_RST_PERIPH_EN;
        end else if (wr_done) begin
            if (idx_hit(address, `DBIO_IDX_FIRST_DATA)) begin
                first_port_latch <= first_wr;
            end
            if (idx_hit(address, `DBIO_IDX_FIRST_SET)) begin
                first_port_latch <= first_read | writedata[5:0];
            end
            if (idx_hit(address, `DBIO_IDX_FIRST_CLR)) begin
                first_port_latch <= first_read & ~writedata[5:0];
            end
            if (idx_hit(address, `DBIO_IDX_FIRST_DIR)) begin
                first_port_direction <= writedata[5:0];
            end
            if (idx_hit(address, `DBIO_IDX_SECOND_DATA)) begin
                second_port_latch <= second_wr;
            end
            if (idx_hit(address, `DBIO_IDX_SECOND_SET)) begin
                second_port_latch <= second_read | writedata[7:0];
            end
            if (idx_hit(address, `DBIO_IDX_SECOND_CLR)) begin
                second_port_latch <= second_read & ~writedata[7:0];
            end
            if (idx_hit(address, `DBIO_IDX_SECOND_DIR)) begin
                second_port_direction <= writedata[7:0];
            end
            if (idx_hit(address, `DBIO_IDX_OPTION)) begin
                option_reg <= writedata[7:0];
            end
            if (idx_hit(address, `DBIO_IDX_ANALOG_CFG)) begin
                analog_pin_config <= writedata[7:0];
            end
            if (idx_hit(address, `DBIO_IDX_PERIPH_EN)) begin
                periph_enable <= writedata[5:0];
            end
        end
    end

    // Pin drivers
    always @* begin
        // Direction still gates analog pins, so software keeps them inputs
        next_first_oe  = ~first_port_direction & first_present;
        next_first_out = first_port_latch;
        // Open drain: only ever pulls low
        next_first_out[`DBIO_FIRST_TIMER_BIT] = 1'b0;
        next_first_oe[`DBIO_FIRST_TIMER_BIT]  = ~first_port_direction[`DBIO_FIRST_TIMER_BIT]
                                              & ~first_port_latch[`DBIO_FIRST_TIMER_BIT];
        if (periph_enable[`DBIO_PER_TIMER_CLK]) begin
            next_first_oe[`DBIO_FIRST_TIMER_BIT] = 1'b0;
        end
        next_second_oe = ~second_port_direction & ~second_periph;
        next_second_pullup = {8{~option_reg[`DBIO_OPT_PULLUP_DIS_N]}}
                           & second_port_direction;
    end

    always @(posedge clock) begin
        if (!resetn) begin
            first_port_out       <= 6'h00;
            first_port_oe        <= 6'h00;
            second_port_out      <= 8'h00;
            second_port_oe       <= 8'h00;
            second_port_pullup   <= 8'h00;
            external_timer_clock <= 1'b0;
            external_interrupt   <= 1'b0;
            slave_select_n       <= 1'b1;
            lowvolt_detect_in    <= 1'b0;
            first_port_analog    <= `DBIO_ANALOG_CAPABLE;
            second_port_analog   <= 2'b00;
            reference_config     <= 3'h0;
        end else begin
            first_port_out       <= next_first_out;
            first_port_oe        <= next_first_oe;
            second_port_out      <= second_port_latch;
            second_port_oe       <= next_second_oe;
            second_port_pullup   <= next_second_pullup;
            external_timer_clock <= first_pins[`DBIO_FIRST_TIMER_BIT] &
                                    periph_enable[`DBIO_PER_TIMER_CLK];
            // Idle levels when the peripheral does not own its pin
            external_interrupt   <= second_pins[0] & periph_enable[`DBIO_PER_EXT_INT];
            slave_select_n       <= ~periph_enable[`DBIO_PER_SLAVE_SEL] | second_pins[1];
            lowvolt_detect_in    <= second_pins[3] & periph_enable[`DBIO_PER_LOWVOLT];
            first_port_analog    <= first_analog & first_present;
            second_port_analog   <= second_analog[3:2];
            reference_config     <= analog_pin_config[`DBIO_VCFG_HI:`DBIO_VCFG_LO];
        end
    end

endmodule // dbio_io_ports

/* File: shared/dbio_consts.vh */
// Register indices, field positions, reset values and widths for the dual I/O ports
`ifndef DBIO_CONSTS_VH
`define DBIO_CONSTS_VH

// Register indices; byte address is four times the index
`define DBIO_IDX_FIRST_DATA      8'h05
`define DBIO_IDX_SECOND_DATA     8'h06
`define DBIO_IDX_OPTION          8'h81
`define DBIO_IDX_FIRST_DIR       8'h85
`define DBIO_IDX_SECOND_DIR      8'h86
`define DBIO_IDX_ANALOG_CFG      8'h9f
`define DBIO_IDX_FIRST_SET       8'hc0
`define DBIO_IDX_FIRST_CLR       8'hc1
`define DBIO_IDX_SECOND_SET      8'hc2
`define DBIO_IDX_SECOND_CLR      8'hc3
`define DBIO_IDX_PERIPH_EN       8'hc4
`define DBIO_IDX_PIN_MODE        8'hc5

// Widths
`define DBIO_ADDR_W              10
`define DBIO_FIRST_W             6
`define DBIO_SECOND_W            8

// Field positions
`define DBIO_OPT_PULLUP_DIS_N    7
`define DBIO_FIRST_TIMER_BIT     4
`define DBIO_FIRST_BIT5          5
`define DBIO_PCFG_LO             0
`define DBIO_PCFG_HI             3
`define DBIO_VCFG_LO             4
`define DBIO_VCFG_HI             6
`define DBIO_PER_EXT_INT         0
`define DBIO_PER_SLAVE_SEL       1
`define DBIO_PER_ANALOG8         2
`define DBIO_PER_ANALOG9         3
`define DBIO_PER_LOWVOLT         4
`define DBIO_PER_TIMER_CLK       5

// Reset values
`define DBIO_RST_FIRST_DIR       6'h3f
`define DBIO_RST_SECOND_DIR      8'hff
`define DBIO_RST_OPTION          8'hff
`define DBIO_RST_ANALOG_CFG      8'h00
`define DBIO_RST_PERIPH_EN       6'h00
`define DBIO_RST_FIRST_LATCH     6'h00
`define DBIO_RST_SECOND_LATCH    8'h00

// Analog-capable pins of the first port
`define DBIO_ANALOG_CAPABLE      6'h2f

`endif

/* File: rtl/dbio_pin_sample.v */
// Input sampling register for the port pins
`timescale 1ns/1ps
module dbio_pin_sample #(
    parameter WIDTH = 14
) (
    // Clock and reset
    input  wire             clock,
    input  wire             resetn,
    // Pin levels in and sampled out
    input  wire [WIDTH-1:0] pins,
    output reg  [WIDTH-1:0] sampled
);

    always @(posedge clock) begin
        if (!resetn) begin
            sampled <= {WIDTH{1'b0}};
        end else begin
            sampled <= pins;
        end
    end

endmodule // dbio_pin_sample

/* File: test/dbio_io_ports_assertions.sv */
// Concurrent checks on the dual I/O port block
`timescale 1ns/1ps
`include "dbio_consts.vh"
module dbio_io_ports_assertions (
    // Clock and reset
    input logic        clock,
    input logic        resetn,
    input logic        small_package,
    // Register bus
    input logic [9:0]  address,
    input logic        read,
    input logic        write,
    input logic [31:0] readdata,
    input logic        waitrequest,
    // Pins and peripheral side
    input logic [5:0]  first_port_out,
    input logic [5:0]  first_port_oe,
    input logic [7:0]  second_port_oe,
    input logic [7:0]  second_port_pullup,
    input logic        external_interrupt,
    input logic        external_timer_clock,
    input logic [5:0]  first_port_analog
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    one_wait_cycle_a: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one wait cycle");
    reset_inputs_a: assert property ($rose(resetn) |-> first_port_oe == 6'h00 && second_port_oe == 8'h00)
        else $error("pins driven right after reset");
    analog_reset_a: assert property ($rose(resetn) |-> first_port_analog == `DBIO_ANALOG_CAPABLE)
        else $error("pins not analog after reset");
    pullup_reset_a: assert property ($rose(resetn) |-> second_port_pullup == 8'h00)
        else $error("pull-ups on after reset");
    open_drain_a: assert property (first_port_out[4] == 1'b0)
        else $error("timer pin driven high");
    absent_pin_a: assert property (small_package && $past(small_package) |-> !first_port_oe[5])
        else $error("absent pin driven");
    pullup_input_a: assert property ((second_port_pullup & second_port_oe) == 8'h00)
        else $error("pull-up on an output pin");
    unused_bits_a: assert property (!waitrequest && read && (address == 10'h014 || address == 10'h214)
        |-> readdata[7:6] == 2'b00)
        else $error("unused bits read nonzero");
    periph_owns_a: assert property (external_interrupt && $past(external_interrupt) |-> !second_port_oe[0])
        else $error("interrupt pin still driven");
    timer_owns_a: assert property (external_timer_clock && $past(external_timer_clock)
        |-> !first_port_oe[4])
        else $error("timer pin still driven");

    cover property (write && !waitrequest);
    cover property (read && !waitrequest);
    cover property (second_port_pullup != 8'h00);
    cover property (external_interrupt);
endmodule // dbio_io_ports_assertions

bind dbio_io_ports dbio_io_ports_assertions i_dbio_io_ports_assertions (
    .clock(clock), .resetn(resetn), .small_package(small_package), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .first_port_out(first_port_out), .first_port_oe(first_port_oe),
    .second_port_oe(second_port_oe), .second_port_pullup(second_port_pullup),
    .external_interrupt(external_interrupt), .external_timer_clock(external_timer_clock),
    .first_port_analog(first_port_analog));

/* File: test/dbio_board_model.sv */
// Board circuitry that resolves the port pin levels
`timescale 1ns/1ps
module dbio_board_model (
    // Clock
    input  logic       clock,
    // Levels the board drives where the block does not
    input  logic [5:0] first_drive,
    input  logic [7:0] second_drive,
    input  logic [7:0] second_float,
    // Block pin outputs
    input  logic [5:0] first_out,
    input  logic [5:0] first_oe,
    input  logic [7:0] second_out,
    input  logic [7:0] second_oe,
    input  logic [7:0] second_pullup,
    // Resolved pin levels
    output logic [5:0] first_in,
    output logic [7:0] second_in
);
    logic [7:0] churn = 8'h55;
    always @(posedge clock) churn <= ~churn;
    // Open drain pin only ever sees a driven zero
    assign first_in = (first_oe & first_out) | (~first_oe & first_drive);
    // Unpulled floating lines flip each cycle so a stale level never reads back
    assign second_in = (second_oe & second_out) | (~second_oe & ~second_float & second_drive)
        | (~second_oe & second_float & (second_pullup | churn));
endmodule // dbio_board_model

/* File: test/dbio_io_ports_test.sv */
// Register-level regression of the dual I/O port block
`timescale 1ns/1ps
`include "dbio_consts.vh"
module dbio_io_ports_test;
    logic clock = 0, resetn = 0, power_on_reset = 1, small_package = 0, read = 0, write = 0;
    logic [9:0]  address = 0;
    logic [31:0] writedata = 0, readdata, rdv;
    logic [3:0]  byteenable = 4'h1;
    logic waitrequest, ext_int, ss_n, tclk, lv;
    logic [5:0]  fa;
    logic [1:0]  sa;
    logic [2:0]  rcf;
    logic [5:0]  fi, fo, foe, b_first = 6'h3f;
    logic [7:0]  si, so, soe, spu, b_second = 0, b_float = 8'hff;
    int err_total = 0, check_count = 0;

    always #50 clock = ~clock;

    dbio_io_ports i_dbio_io_ports (.clock(clock), .resetn(resetn),
        .power_on_reset(power_on_reset), .small_package(small_package), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .first_port_in(fi),
        .first_port_out(fo), .first_port_oe(foe), .second_port_in(si), .second_port_out(so),
        .second_port_oe(soe), .second_port_pullup(spu), .external_timer_clock(tclk),
        .external_interrupt(ext_int), .slave_select_n(ss_n), .lowvolt_detect_in(lv),
        .first_port_analog(fa), .second_port_analog(sa), .reference_config(rcf));

    dbio_board_model i_dbio_board_model (.clock(clock), .first_drive(b_first),
        .second_drive(b_second), .second_float(b_float), .first_out(fo), .first_oe(foe),
        .second_out(so), .second_oe(soe), .second_pullup(spu), .first_in(fi), .second_in(si));

    task complete_run;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    // Request held until waitrequest is sampled low at a rising edge
    task bus(input logic [7:0] i, input logic w, input logic [7:0] d);
        int n;
        address <= {i, 2'b00};
        writedata <= {24'h0, d};
        read <= !w;
        write <= w;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        if (n >= 40) err_total++;
        rdv = readdata;
        read <= 0;
        write <= 0;
        @(posedge clock);
    endtask

    task wr(input logic [7:0] i, input logic [7:0] d);
        bus(i, 1'b1, d);
    endtask

    task rc(input string n, input logic [7:0] i, input logic [31:0] e);
        bus(i, 1'b0, 8'h00);
        chk(n, rdv, e);
    endtask

    task rst(input logic po);
        resetn <= 0;
        power_on_reset <= po;
        repeat (16) @(posedge clock);
        resetn <= 1;
        @(posedge clock);
    endtask

    task settle;
        repeat (3) @(posedge clock);
    endtask

    initial begin
        rst(1'b1);
        rc("dir", `DBIO_IDX_FIRST_DIR, 32'h3f);
        rc("cfg", `DBIO_IDX_ANALOG_CFG, 32'h00);
        rc("data", `DBIO_IDX_FIRST_DATA, 32'h10);
        rc("mode", `DBIO_IDX_PIN_MODE, 32'h2f);
        chk("pullup", spu, 8'h00);
        chk("analog", fa, 6'h2f);
        $display("test power_on done");
        wr(`DBIO_IDX_ANALOG_CFG, 8'h06);
        b_first <= 6'h15;
        rc("mode", `DBIO_IDX_PIN_MODE, 32'h00);
        chk("analog", fa, 6'h00);
        chk("vref", rcf, 3'h0);
        rc("data", `DBIO_IDX_FIRST_DATA, 32'h15);
        wr(`DBIO_IDX_FIRST_DIR, 8'hff);
        rc("dir", `DBIO_IDX_FIRST_DIR, 32'h3f);
        // Set on an input-only port folds the pin levels into the latch
        wr(`DBIO_IDX_FIRST_SET, 8'h02);
        wr(`DBIO_IDX_FIRST_DIR, 8'h00);
        settle;
        chk("oe", foe, 6'h2f);
        chk("out", fo & foe, 6'h07);
        rc("data", `DBIO_IDX_FIRST_DATA, 32'h17);
        $display("test first_port done");
        rst(1'b0);
        wr(`DBIO_IDX_ANALOG_CFG, 8'h06);
        wr(`DBIO_IDX_FIRST_DIR, 8'h00);
        settle;
        chk("oe", foe, 6'h2f);
        rc("data", `DBIO_IDX_FIRST_DATA, 32'h10);
        small_package <= 1;
        b_first <= 6'h3f;
        rst(1'b1);
        wr(`DBIO_IDX_ANALOG_CFG, 8'h06);
        wr(`DBIO_IDX_FIRST_DIR, 8'h00);
        settle;
        chk("oe", foe, 6'h1f);
        rc("data", `DBIO_IDX_FIRST_DATA, 32'h00);
        $display("test resets done");
        wr(`DBIO_IDX_OPTION, 8'h7f);
        settle;
        chk("pullup", spu, 8'hff);
        wr(`DBIO_IDX_SECOND_DIR, 8'h0f);
        wr(`DBIO_IDX_SECOND_DATA, 8'ha5);
        settle;
        chk("pullup", spu, 8'h0f);
        chk("oe", soe, 8'hf0);
        chk("out", so & soe, 8'ha0);
        rc("data", `DBIO_IDX_SECOND_DATA, 32'haf);
        $display("test second_port done");
        b_float <= 8'h00;
        b_second <= 8'h01;
        wr(`DBIO_IDX_PERIPH_EN, 8'h03);
        wr(`DBIO_IDX_SECOND_DIR, 8'h00);
        settle;
        chk("oe", soe, 8'hfc);
        chk("int", ext_int, 1'b1);
        chk("select", ss_n, 1'b0);
        chk("pullup", spu, 8'h00);
        rc("unmapped", 8'hff, 32'h00);
        // Analog 8/9, low-volt and timer clock take their pins
        b_second <= 8'h09;
        wr(`DBIO_IDX_PERIPH_EN, 8'h3c);
        settle;
        chk("analog2", sa, 2'b11);
        chk("lowvolt", lv, 1'b1);
        chk("timer", tclk, 1'b1);
        chk("oe", foe, 6'h0f);
        $display("test peripherals done");
        complete_run;
    end

    initial begin
        repeat (6000) @(posedge clock);
        err_total++;
        complete_run;
    end
endmodule // dbio_io_ports_test
